// file: core/uic_consts.vh
// Purpose: Shared constants of the UART interrupt, clear and DMA-request block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes:   Flag vectors are 13 bits wide and keep the register bit positions.
`ifndef UIC_CONSTS_VH
`define UIC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UIC_OFF_MASK 8'h38
`define UIC_OFF_RAW 8'h3c
`define UIC_OFF_MIS 8'h40
`define UIC_OFF_CLR 8'h44
`define UIC_OFF_DMA 8'h48

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define UIC_FLAG_W 13
`define UIC_B_CTS 1
`define UIC_B_RX 4
`define UIC_B_TX 5
`define UIC_B_RTO 6
`define UIC_B_FE 7
`define UIC_B_PE 8
`define UIC_B_BE 9
`define UIC_B_OE 10
`define UIC_B_XOFF 11
`define UIC_B_TXFE 12
`define UIC_FLAG_IMPL 13'h1ff2
`define UIC_FLAG_ERR 13'h0780
`define UIC_FLAG_RST 13'h0000

// ----------------------------------------------------------------
// DMA control fields
// ----------------------------------------------------------------
`define UIC_DMA_W 4
`define UIC_D_RXE 0
`define UIC_D_TXE 1
`define UIC_D_STOP 3
`define UIC_DMA_IMPL 4'hb
`define UIC_DMA_RST 4'h0

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define UIC_RESP_OKAY 2'h0
`define UIC_RESP_SLVERR 2'h2
`define UIC_WORD_ZERO 32'h0000_0000

`endif

// file: core/uic_flag_bank.v
// Purpose: Sticky pending flags set by hardware events, cleared by software.
// Assumes: Set and clear pulses are on the aclk domain.
// Notes:   A set in the same cycle as a clear leaves the flag set.
`include "uic_consts.vh"

module uic_flag_bank #(
  parameter W = 13
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] set_i,
  input wire [W-1:0] clr_i,
  input wire [W-1:0] impl_i,
  output reg [W-1:0] flags_q
);

  wire [W-1:0] flags_d;

  // Set wins over clear; unimplemented positions stay zero
  assign flags_d = (set_i | (flags_q & ~clr_i)) & impl_i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= {W{1'b0}};
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// file: core/uic_top.v
// Purpose: Interrupt status, mask, clear and DMA-request control of a UART.
// Assumes: Event and DMA-want inputs come from UART logic on aclk.
// Notes:   Registers sit behind an AXI4-Lite slave; read data comes one cycle after the handshake, the write answer one cycle later.
//
// Overview of operation
// - Raw flags: CTS change bit 1, receive 4, transmit 5, receive timeout 6.
// - Raw flags: framing 7, parity 8, break 9, overrun 10.
// - Raw flags: XOFF 11, TX FIFO empty 12; read-only, reset to zero.
// - Masked status read-only: CTS bit 1, receive 4, transmit 5, timeout 6.
// - Masked status error flags at bits 7 to 10.
// - Masked status XOFF bit 11, TX empty 12; bits 31:13 read zero.
// - Clear register: one clears CTS, receive, transmit, timeout; zero does nothing.
// - Clear register bits 7 to 10 clear the error flags.
// - Clear register bit 11 clears XOFF, bit 12 clears TX empty.
// - Receive DMA requests only while DMA control bit 0 set; resets off.
// - Transmit DMA requests only while DMA control bit 1 set; resets off.
// - With DMA control bit 3 set, error interrupt suppresses receive DMA.
// - Mask bit one enables its source, zero disables; reads back.
//
// The AXI4-Lite register port is this design's own decision.
`include "uic_consts.vh"

module uic_top #(
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt events from the UART datapath, one-cycle pulses
  input wire cts_change_evt,
  input wire receive_evt,
  input wire transmit_evt,
  input wire rx_timeout_evt,
  input wire framing_err_evt,
  input wire parity_err_evt,
  input wire break_err_evt,
  input wire overrun_err_evt,
  input wire flow_stop_evt,
  input wire tx_fifo_empty_evt,
  // DMA request conditions from the UART datapath, levels
  input wire rx_dma_want,
  input wire tx_dma_want,
  // Outputs to the interrupt and DMA controllers
  output reg uart_irq,
  output reg rx_dma_req,
  output reg tx_dma_req
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into an old word
  function [31:0] strb_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old_w;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_w[i*8 +: 8];
        end
      end
    end
  endfunction

  // Word-index compare of a bus address against a register offset
  function hit;
    input [ADDR_W-1:0] addr;
    input [7:0] off;
    begin
      hit = (addr[ADDR_W-1:2] == {{(ADDR_W-8){1'b0}}, off[7:2]});
    end
  endfunction

  // Known-offset check used by both read and write decode
  function mapped;
    input [ADDR_W-1:0] addr;
    begin
      mapped = hit(addr, `UIC_OFF_MASK) | hit(addr, `UIC_OFF_RAW) |
               hit(addr, `UIC_OFF_MIS) | hit(addr, `UIC_OFF_CLR) |
               hit(addr, `UIC_OFF_DMA);
    end
  endfunction

  // Zero-extension of a flag vector to a bus word
  function [31:0] flag_word;
    input [`UIC_FLAG_W-1:0] f;
    begin
      flag_word = {{(32-`UIC_FLAG_W){1'b0}}, f};
    end
  endfunction

  // Zero-extension of the DMA control field to a bus word
  function [31:0] dma_field_word;
    input [`UIC_DMA_W-1:0] d;
    begin
      dma_field_word = {{(32-`UIC_DMA_W){1'b0}}, d};
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg aw_full_q;
  reg w_full_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [`UIC_FLAG_W-1:0] mask_q;
  reg [`UIC_DMA_W-1:0] dma_q;

  wire [`UIC_FLAG_W-1:0] raw_q;
  wire [`UIC_FLAG_W-1:0] masked;
  reg [`UIC_FLAG_W-1:0] evt_vec;
  wire [`UIC_FLAG_W-1:0] clr_vec;
  wire [31:0] clr_word;
  wire [31:0] mask_word;
  wire [31:0] dma_word;
  wire do_write;
  wire wr_mask_sel;
  wire wr_clr_sel;
  wire wr_dma_sel;
  wire wr_known;
  wire rd_known;
  wire err_irq;
  reg [31:0] rd_word;

  // ----------------------------------------------------------------
  // Event vector and sticky raw flags
  // ----------------------------------------------------------------
  // Reserved positions carry no event
  always @* begin
    evt_vec = {`UIC_FLAG_W{1'b0}};
    evt_vec[`UIC_B_CTS] = cts_change_evt;
    evt_vec[`UIC_B_RX] = receive_evt;
    evt_vec[`UIC_B_TX] = transmit_evt;
    evt_vec[`UIC_B_RTO] = rx_timeout_evt;
    evt_vec[`UIC_B_FE] = framing_err_evt;
    evt_vec[`UIC_B_PE] = parity_err_evt;
    evt_vec[`UIC_B_BE] = break_err_evt;
    evt_vec[`UIC_B_OE] = overrun_err_evt;
    evt_vec[`UIC_B_XOFF] = flow_stop_evt;
    evt_vec[`UIC_B_TXFE] = tx_fifo_empty_evt;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Write selects use the held address, read selects the live one
  assign wr_mask_sel = hit(aw_addr_q, `UIC_OFF_MASK);
  assign wr_clr_sel = hit(aw_addr_q, `UIC_OFF_CLR);
  assign wr_dma_sel = hit(aw_addr_q, `UIC_OFF_DMA);
  assign wr_known = mapped(aw_addr_q);
  assign rd_known = mapped(s_axi_araddr);

  // A write lands once address and data are both held and no answer waits
  assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;

  // Only enabled byte lanes of a clear write take effect
  assign clr_word = strb_merge(`UIC_WORD_ZERO, w_data_q, w_strb_q);
  assign clr_vec = (do_write & wr_clr_sel) ?
                   clr_word[`UIC_FLAG_W-1:0] : {`UIC_FLAG_W{1'b0}};

  uic_flag_bank #(
    .W(`UIC_FLAG_W)
  ) u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_i(evt_vec),
    .clr_i(clr_vec),
    .impl_i(`UIC_FLAG_IMPL),
    .flags_q(raw_q)
  );

  assign masked = raw_q & mask_q;
  assign err_irq = |(masked & `UIC_FLAG_ERR);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign mask_word = strb_merge(flag_word(mask_q), w_data_q, w_strb_q);
  assign dma_word = strb_merge(dma_field_word(dma_q), w_data_q, w_strb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= `UIC_WORD_ZERO;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UIC_RESP_OKAY;
      mask_q <= `UIC_FLAG_RST;
      dma_q <= `UIC_DMA_RST;
    end else begin
      // Ready stays low while a word is held, so one write at most is in flight
      if (!aw_full_q && !s_axi_bvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_full_q && !s_axi_bvalid && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `UIC_RESP_OKAY : `UIC_RESP_SLVERR;
        if (wr_mask_sel) begin
          mask_q <= mask_word[`UIC_FLAG_W-1:0] & `UIC_FLAG_IMPL;
        end
        if (wr_dma_sel) begin
          dma_q <= dma_word[`UIC_DMA_W-1:0] & `UIC_DMA_IMPL;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @* begin
    rd_word = `UIC_WORD_ZERO;
    if (hit(s_axi_araddr, `UIC_OFF_MASK)) begin
      rd_word = flag_word(mask_q);
    end else if (hit(s_axi_araddr, `UIC_OFF_RAW)) begin
      rd_word = flag_word(raw_q);
    end else if (hit(s_axi_araddr, `UIC_OFF_MIS)) begin
      rd_word = flag_word(masked);
    end else if (hit(s_axi_araddr, `UIC_OFF_DMA)) begin
      rd_word = dma_field_word(dma_q);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `UIC_WORD_ZERO;
      s_axi_rresp <= `UIC_RESP_OKAY;
    end else begin
      if (!s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      // Data and answer are latched from the address at the handshake edge
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? `UIC_RESP_OKAY : `UIC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and DMA request outputs
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      uart_irq <= 1'b0;
      rx_dma_req <= 1'b0;
      tx_dma_req <= 1'b0;
    end else begin
      // Each output leaves a flip-flop one edge after its inputs change
      uart_irq <= |masked;
      rx_dma_req <= rx_dma_want & dma_q[`UIC_D_RXE] &
                    ~(dma_q[`UIC_D_STOP] & err_irq);
      tx_dma_req <= tx_dma_want & dma_q[`UIC_D_TXE];
    end
  end

endmodule

// file: verif/uic_top_asserts.sv
// Purpose: Port checks of uic_top: bus answers, DMA requests, interrupt.
// Assumes: One aclk domain, aresetn synchronous active low.
// Notes:   Bound to every uic_top.
module uic_top_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire rx_dma_want,
  input wire tx_dma_want,
  input wire uart_irq,
  input wire rx_dma_req,
  input wire tx_dma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Properties
  // ----------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
    !uart_irq && !rx_dma_req && !tx_dma_req && !s_axi_bvalid && !s_axi_rvalid) else $error("active in reset");
  rx_off_a: assert property (!rx_dma_want |=> !rx_dma_req) else $error("rx request unwanted");
  tx_off_a: assert property (!tx_dma_want |=> !tx_dma_req) else $error("tx request unwanted");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("no write response");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  irq_fall_a: assert property ($fell(uart_irq) |-> $past(s_axi_bvalid)) else $error("irq fell alone");
endmodule

bind uic_top uic_top_asserts i_uic_top_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .rx_dma_want(rx_dma_want), .tx_dma_want(tx_dma_want), .uart_irq(uart_irq),
  .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));

// file: verif/uic_dp_model.sv
// Purpose: UART datapath stand-in that raises interrupt events.
// Assumes: Commands come from the bench on aclk.
// Notes:   Each fire bit becomes an event pulse one edge later.
module uic_dp_model (
  input wire aclk,
  input wire [12:0] fire,
  output logic [12:0] evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt = 13'h0000;
  always @(posedge aclk) begin
    evt <= fire;
  end
endmodule

// file: verif/uic_top_tb.sv
// Purpose: Register, interrupt and DMA request tests of uic_top.
// Assumes: AXI4-Lite master tasks, one access at a time.
// Notes:   Events come from uic_dp_model.
`include "uic_consts.vh"
module uic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic rx_dma_want = 1'b0, tx_dma_want = 1'b0;
  logic [12:0] fire = 13'h0000;
  wire [12:0] evt;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, uart_irq, rx_dma_req, tx_dma_req;
  int error_cnt = 0;
  int comparisons = 0;
  int srcs[10] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12};
  logic [5:0] dma_tab[6] = '{6'h00, 6'h06, 6'h09, 6'h0f, 6'h24, 6'h2d};
  always #5 aclk = ~aclk;
  uic_dp_model i_uic_dp_model (.aclk(aclk), .fire(fire), .evt(evt));
  uic_top i_uic_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cts_change_evt(evt[1]), .receive_evt(evt[4]), .transmit_evt(evt[5]),
    .rx_timeout_evt(evt[6]), .framing_err_evt(evt[7]), .parity_err_evt(evt[8]), .break_err_evt(evt[9]),
    .overrun_err_evt(evt[10]), .flow_stop_evt(evt[11]), .tx_fifo_empty_evt(evt[12]),
    .rx_dma_want(rx_dma_want), .tx_dma_want(tx_dma_want), .uart_irq(uart_irq),
    .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));
  // -----
  // Tasks
  // -----
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk({31'h0, s_axi_bvalid}, 32'h1);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    chk({31'h0, s_axi_rvalid}, 32'h1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task automatic pulse(input logic [12:0] m);
    @(posedge aclk);
    fire <= m;
    @(posedge aclk);
    fire <= 13'h0000;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`UIC_OFF_RAW, 32'h0, 2'h0);
    rd(`UIC_OFF_CLR, 32'h0, 2'h0);
    rd(`UIC_OFF_DMA, 32'h0, 2'h0);
    wr(`UIC_OFF_MASK, 32'hffff_ffff, 2'h0);
    rd(`UIC_OFF_MASK, 32'h0000_1ff2, 2'h0);
    wr(`UIC_OFF_RAW, 32'hffff_ffff, 2'h0);
    rd(`UIC_OFF_RAW, 32'h0, 2'h0);
    wr(8'h04, 32'hffff_ffff, 2'h2);
    rd(8'h04, 32'h0, 2'h2);
    foreach (srcs[i]) begin
      pulse(13'h0001 << srcs[i]);
      rd(`UIC_OFF_RAW, 32'h1 << srcs[i], 2'h0);
      rd(`UIC_OFF_MIS, 32'h1 << srcs[i], 2'h0);
      chk({31'h0, uart_irq}, 32'h1);
      wr(`UIC_OFF_CLR, ~(32'h1 << srcs[i]), 2'h0);
      rd(`UIC_OFF_RAW, 32'h1 << srcs[i], 2'h0);
      wr(`UIC_OFF_CLR, 32'h1 << srcs[i], 2'h0);
      rd(`UIC_OFF_MIS, 32'h0, 2'h0);
    end
    pulse(13'h1ff2);
    wr(`UIC_OFF_MASK, 32'h0000_0500, 2'h0);
    rd(`UIC_OFF_MIS, 32'h0000_0500, 2'h0);
    wr(`UIC_OFF_MASK, 32'h0000_0780, 2'h0);
    s_axi_wstrb <= 4'h1;
    wr(`UIC_OFF_MASK, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(`UIC_OFF_MASK, 32'h0000_0700, 2'h0);
    rx_dma_want <= 1'b1;
    tx_dma_want <= 1'b1;
    wr(`UIC_OFF_DMA, 32'hffff_ffff, 2'h0);
    rd(`UIC_OFF_DMA, 32'h0000_000b, 2'h0);
    foreach (dma_tab[i]) begin
      wr(`UIC_OFF_DMA, {28'h0, dma_tab[i][5:2]}, 2'h0);
      repeat (2) @(posedge aclk);
      chk({30'h0, rx_dma_req, tx_dma_req}, {30'h0, dma_tab[i][1:0]});
    end
    wr(`UIC_OFF_MASK, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    chk({29'h0, uart_irq, rx_dma_req, tx_dma_req}, 32'h3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`UIC_OFF_RAW, 32'h0, 2'h0);
    rd(`UIC_OFF_DMA, 32'h0, 2'h0);
    wrap_up;
  end
endmodule
